// file: hw/asfm_map.svh
// constants for the amplifier state and fault manager
`ifndef ASFM_MAP_SVH
`define ASFM_MAP_SVH

// ==========================================
// clock, timing and channel count
`define ASFM_CLK_MHZ 25
`define ASFM_OC_TIME_US 100
`define ASFM_OC_CYCLES (`ASFM_OC_TIME_US * `ASFM_CLK_MHZ)
`define ASFM_DIAG_TIME_US 40
`define ASFM_DIAG_CYCLES (`ASFM_DIAG_TIME_US * `ASFM_CLK_MHZ)
`define ASFM_CNT_W 12
`define ASFM_CHANNELS 4

// ==========================================
// clip/warning pin source select
`define ASFM_CLIP_SEL_NONE 2'h0
`define ASFM_CLIP_SEL_WARN 2'h1
`define ASFM_CLIP_SEL_CLIP 2'h2
`define ASFM_CLIP_SEL_BOTH 2'h3

// ==========================================
// positions in the synchronised pin vector
`define ASFM_SY_STBY_N 0
`define ASFM_SY_SCLK 1
`define ASFM_SY_TENTH 2
`define ASFM_SY_THIRD 3
`define ASFM_SY_TWO_THIRDS 4
`define ASFM_SY_NINE_TENTHS 5
`define ASFM_SY_POR 6
`define ASFM_SY_UV 7
`define ASFM_SY_CPUV 8
`define ASFM_SY_OV 9
`define ASFM_SY_LDUMP 10
`define ASFM_SY_OTW 11
`define ASFM_SY_OVERHEAT_SHUTDOWN 12
`define ASFM_SY_CBC 13
`define ASFM_SY_DC 17
`define ASFM_SY_CLIP 21
`define ASFM_SY_DOPEN 25
`define ASFM_SY_DSHORT 29
`define ASFM_SYNC_W 33

`endif

// file: hw/asfm_pkg.sv
// types for the amplifier state and fault manager
`include "asfm_map.svh"
package asfm_pkg;

	// ==========================================
	// operating state, gray coded along standby-hiz-mute-ramp-play
	typedef enum logic [2:0]
	{
		ASFM_ST_STANDBY = 3'h0,
		ASFM_ST_HIZ = 3'h1,
		ASFM_ST_MUTE = 3'h3,
		ASFM_ST_RAMP_UP = 3'h2,
		ASFM_ST_PLAY = 3'h6,
		ASFM_ST_RAMP_DOWN = 3'h7
	} asfm_state_t;

	typedef logic [`ASFM_CHANNELS-1:0] asfm_chan_t;

	// ==========================================
	// whole state of the manager core
	typedef struct packed
	{
		asfm_state_t state;
		logic uv;
		logic cpuv;
		logic ov;
		logic overheat_shutdown;
		logic overheat_warning;
		asfm_chan_t oc;
		asfm_chan_t dcf;
		asfm_chan_t dopen;
		asfm_chan_t dshort;
		logic [`ASFM_CHANNELS-1:0][`ASFM_CNT_W-1:0] oc_cnt;
		logic diag_busy;
		logic [`ASFM_CNT_W-1:0] diag_cnt;
		logic sclk_prev;
		logic phase;
		logic fault_act;
		logic clip_act;
	} asfm_core_t;

	// ==========================================
	// synchroniser state
	typedef struct packed
	{
		logic [`ASFM_SYNC_W-1:0] stage1;
		logic [`ASFM_SYNC_W-1:0] stage2;
	} asfm_sync_state_t;

endpackage

// file: hw/asfm_sync_if.sv
// carrier between the manager core and its pin synchroniser
`timescale 1ns/1ps
`include "asfm_map.svh"
interface asfm_sync_if;
	logic [`ASFM_SYNC_W-1:0] raw;
	logic [`ASFM_SYNC_W-1:0] synced;
	modport owner (output raw, input synced);
	modport syncer (input raw, output synced);
endinterface

// file: hw/asfm_sync.sv
// two-stage synchroniser for every asynchronous pin of the manager
`timescale 1ns/1ps
module asfm_sync
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	asfm_sync_if.syncer bus
);
	import asfm_pkg::*;

	asfm_sync_state_t state_reg;
	asfm_sync_state_t state_next;

	// ==========================================
	// first stage feeds only the second
	always_comb
	begin
		state_next = state_reg;
		state_next.stage1 = bus.raw;
		state_next.stage2 = state_reg.stage1;
	end

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign bus.synced = state_reg.stage2;
endmodule

// file: hw/asfm_core.sv
// operating-state and fault manager for a four-channel switching amplifier
// Function
// - standby floats bridges and stops charge pump, oscillator and serial port.
// - mute keeps each bridge switching at 50% duty without audio, supplies on.
// - power-on fault forces hard mute and standby, fault pin only, self-clearing.
// - undervoltage, pump undervoltage, overvoltage force hi-z, reported and latched.
// - overheat warning reported on status and clip pin, no action, self-clearing.
// - overheat shutdown hard mutes, enters standby, reported and latched.
// - load diagnostic runs only in hi-z on command, result latched in status.
// - current limit in mute or play limits, shows on clip pin, starts timer.
// - channel overcurrent or dc fault hard mutes that channel into hi-z, latched.
// - mute ramp gain falls between 2/3 and 1/3 of bypass reference.
// - mute status changes only once ramp pin falls to 1/10 of reference.
// - play ramp gain rises between 1/3 and 2/3 of bypass reference.
// - play status changes only once ramp pin reaches 9/10 of reference.
// - ramp pin starts moving as soon as the mode command arrives.
// - ramp length follows the external capacitor; wait on thresholds, not counts.
// - load diagnostic stays usable with channels paralleled.
// - fault pin, active low open drain, asserts on any hi-z or standby fault.
// - clip pin active low, shows warning, clipping or both by setting.
// - standby pin shuts everything down and loses all register contents.
`timescale 1ns/1ps
`include "asfm_map.svh"
module asfm_core
#(
	parameter logic [`ASFM_CNT_W-1:0] OC_TIMEOUT = `ASFM_CNT_W'(`ASFM_OC_CYCLES),
	parameter logic [`ASFM_CNT_W-1:0] DIAG_TIME = `ASFM_CNT_W'(`ASFM_DIAG_CYCLES)
)
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic standby_n_i,
	input wire logic sync_clock_i,
	input wire logic ramp_above_tenth_i,
	input wire logic ramp_above_third_i,
	input wire logic ramp_above_two_thirds_i,
	input wire logic ramp_above_nine_tenths_i,
	input wire logic por_fault_i,
	input wire logic supply_undervoltage_i,
	input wire logic charge_pump_undervoltage_i,
	input wire logic supply_overvoltage_i,
	input wire logic load_dump_i,
	input wire logic overheat_warning_i,
	input wire logic overheat_shutdown_i,
	input wire logic [3:0] cycle_current_limit_i,
	input wire logic [3:0] dc_fault_i,
	input wire logic [3:0] clip_detect_i,
	input wire logic [3:0] diag_open_i,
	input wire logic [3:0] diag_short_i,
	input wire logic cmd_play_i,
	input wire logic [3:0] cmd_hiz_i,
	input wire logic diag_start_i,
	input wire logic fault_clear_i,
	input wire logic [1:0] clip_select_i,
	output asfm_pkg::asfm_state_t dev_state_o,
	output logic charge_pump_en_o,
	output logic osc_en_o,
	output logic serial_en_o,
	output logic ramp_charge_o,
	output logic ramp_hard_discharge_o,
	output logic gain_ramping_o,
	output logic [3:0] bridge_hiz_o,
	output logic [3:0] bridge_switch_o,
	output logic [3:0] audio_enable_o,
	output logic [3:0] current_limit_o,
	output logic status_mute_o,
	output logic status_play_o,
	output logic stat_undervoltage_o,
	output logic stat_charge_pump_undervoltage_o,
	output logic stat_overvoltage_o,
	output logic stat_overheat_warning_o,
	output logic stat_overheat_shutdown_o,
	output logic [3:0] stat_overcurrent_o,
	output logic [3:0] stat_dc_fault_o,
	output logic [3:0] stat_diag_open_o,
	output logic [3:0] stat_diag_short_o,
	output logic diag_busy_o,
	output logic fault_out_o,
	output logic fault_oe_n_o,
	output logic clip_heat_warning_n_o
);
	import asfm_pkg::*;

	// ==========================================
	// state decoding and latch helpers
	function automatic logic is_running(input asfm_state_t st);
		is_running = (st == ASFM_ST_MUTE) || (st == ASFM_ST_RAMP_UP) ||
			(st == ASFM_ST_PLAY) || (st == ASFM_ST_RAMP_DOWN);
	endfunction

	function automatic logic is_ramping(input asfm_state_t st);
		is_ramping = (st == ASFM_ST_RAMP_UP) || (st == ASFM_ST_PLAY) || (st == ASFM_ST_RAMP_DOWN);
	endfunction

	function automatic logic hold_latch(input logic held, input logic set, input logic clear);
		hold_latch = set || (held && !clear);
	endfunction

	// ==========================================
	// pin synchronisation
	asfm_sync_if sync_bus ();

	assign sync_bus.raw = {diag_short_i, diag_open_i, clip_detect_i, dc_fault_i, cycle_current_limit_i,
		overheat_shutdown_i, overheat_warning_i, load_dump_i, supply_overvoltage_i,
		charge_pump_undervoltage_i, supply_undervoltage_i, por_fault_i,
		ramp_above_nine_tenths_i, ramp_above_two_thirds_i, ramp_above_third_i, ramp_above_tenth_i,
		sync_clock_i, standby_n_i};

	asfm_sync u_sync
	(
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.bus(sync_bus.syncer)
	);

	logic [`ASFM_SYNC_W-1:0] s;
	logic s_tenth, s_third, s_two_thirds, s_nine_tenths;
	logic s_por, s_ldump, s_otw, s_overheat_shutdown;
	logic [3:0] s_cbc, s_dc, s_clip, s_dopen, s_dshort;

	assign s = sync_bus.synced;
	assign s_tenth = s[`ASFM_SY_TENTH];
	assign s_third = s[`ASFM_SY_THIRD];
	assign s_two_thirds = s[`ASFM_SY_TWO_THIRDS];
	assign s_nine_tenths = s[`ASFM_SY_NINE_TENTHS];
	assign s_por = s[`ASFM_SY_POR];
	assign s_ldump = s[`ASFM_SY_LDUMP];
	assign s_otw = s[`ASFM_SY_OTW];
	assign s_overheat_shutdown = s[`ASFM_SY_OVERHEAT_SHUTDOWN];
	assign s_cbc = s[`ASFM_SY_CBC +: 4];
	assign s_dc = s[`ASFM_SY_DC +: 4];
	assign s_clip = s[`ASFM_SY_CLIP +: 4];
	assign s_dopen = s[`ASFM_SY_DOPEN +: 4];
	assign s_dshort = s[`ASFM_SY_DSHORT +: 4];

	// ==========================================
	// manager state
	asfm_core_t state_reg;
	asfm_core_t state_next;
	logic running;
	logic global_hiz;
	logic force_standby;
	logic [3:0] chan_hiz;
	logic [3:0] limiting;
	logic [3:0] clipping;

	assign running = is_running(state_reg.state);
	assign global_hiz = state_reg.uv || state_reg.cpuv || state_reg.ov;
	assign force_standby = s_por || s_ldump || state_reg.overheat_shutdown;
	assign chan_hiz = cmd_hiz_i | state_reg.oc | state_reg.dcf | {4{!running}};
	assign limiting = s_cbc & ~chan_hiz;
	assign clipping = s_clip & ~chan_hiz & {4{state_reg.state == ASFM_ST_PLAY}};

	always_comb
	begin
		logic monitor;
		logic warn_src;
		logic clip_src;
		monitor = state_reg.state != ASFM_ST_STANDBY;
		warn_src = 1'b0;
		clip_src = 1'b0;
		state_next = state_reg;

		// global latched faults, set wins over clear; overheat warning follows its pin unlatched
		state_next.uv = hold_latch(state_reg.uv, monitor && s[`ASFM_SY_UV], fault_clear_i);
		state_next.cpuv = hold_latch(state_reg.cpuv, monitor && s[`ASFM_SY_CPUV], fault_clear_i);
		state_next.ov = hold_latch(state_reg.ov, monitor && s[`ASFM_SY_OV], fault_clear_i);
		state_next.overheat_shutdown = hold_latch(state_reg.overheat_shutdown, monitor && s_overheat_shutdown, fault_clear_i);
		state_next.overheat_warning = monitor && s_otw;

		// mute/play sequencing on ramp thresholds, gray-coded except the direct ramp-up/ramp-down reversal
		case (state_reg.state)
			ASFM_ST_STANDBY:
			begin
				if (!force_standby)
					state_next.state = ASFM_ST_HIZ;
			end
			ASFM_ST_HIZ:
			begin
				if (!global_hiz)
					state_next.state = ASFM_ST_MUTE;
			end
			ASFM_ST_MUTE:
			begin
				if (cmd_play_i)
					state_next.state = ASFM_ST_RAMP_UP;
			end
			ASFM_ST_RAMP_UP:
			begin
				if (!cmd_play_i)
					state_next.state = ASFM_ST_RAMP_DOWN;
				else if (s_nine_tenths)
					state_next.state = ASFM_ST_PLAY;
			end
			ASFM_ST_PLAY:
			begin
				if (!cmd_play_i)
					state_next.state = ASFM_ST_RAMP_DOWN;
			end
			ASFM_ST_RAMP_DOWN:
			begin
				if (cmd_play_i)
					state_next.state = ASFM_ST_RAMP_UP;
				else if (!s_tenth)
					state_next.state = ASFM_ST_MUTE;
			end
			default:
			begin
				state_next.state = ASFM_ST_STANDBY;
			end
		endcase
		if (global_hiz && running)
			state_next.state = ASFM_ST_HIZ;
		if (force_standby)
			state_next.state = ASFM_ST_STANDBY;

		// per-channel faults and overcurrent timers
		for (int i = 0; i < 4; i++)
		begin
			if (limiting[i] && state_reg.oc_cnt[i] != OC_TIMEOUT)
				state_next.oc_cnt[i] = state_reg.oc_cnt[i] + `ASFM_CNT_W'(1);
			else if (!limiting[i])
				state_next.oc_cnt[i] = '0;
			state_next.oc[i] = hold_latch(state_reg.oc[i],
				limiting[i] && state_reg.oc_cnt[i] == OC_TIMEOUT - `ASFM_CNT_W'(1), fault_clear_i);
			state_next.dcf[i] = hold_latch(state_reg.dcf[i],
				s_dc[i] && !chan_hiz[i] && state_reg.state == ASFM_ST_PLAY, fault_clear_i);
		end

		// load diagnostic, all channels hi-z so paralleled pairs are tested together
		if (state_reg.diag_busy)
		begin
			if (!(&chan_hiz) || !monitor)
				state_next.diag_busy = 1'b0;
			else if (state_reg.diag_cnt == DIAG_TIME - `ASFM_CNT_W'(1))
			begin
				state_next.diag_busy = 1'b0;
				state_next.dopen = s_dopen;
				state_next.dshort = s_dshort;
			end
			else
				state_next.diag_cnt = state_reg.diag_cnt + `ASFM_CNT_W'(1);
		end
		else if (diag_start_i && monitor && (&chan_hiz))
		begin
			state_next.diag_busy = 1'b1;
			state_next.diag_cnt = '0;
		end

		// mute carrier: one toggle per rising sync edge gives exactly half duty
		state_next.sclk_prev = s[`ASFM_SY_SCLK];
		if (s[`ASFM_SY_SCLK] && !state_reg.sclk_prev)
			state_next.phase = !state_reg.phase;

		// fault and clip/warning pins
		state_next.fault_act = s_por || s_ldump || state_next.overheat_shutdown || state_next.uv || state_next.cpuv ||
			state_next.ov || (|state_next.oc) || (|state_next.dcf);
		warn_src = state_next.overheat_warning;
		clip_src = (|clipping) || (|limiting);
		case (clip_select_i)
			`ASFM_CLIP_SEL_WARN: state_next.clip_act = warn_src;
			`ASFM_CLIP_SEL_CLIP: state_next.clip_act = clip_src;
			`ASFM_CLIP_SEL_BOTH: state_next.clip_act = warn_src || clip_src;
			default: state_next.clip_act = 1'b0;
		endcase

		// standby pin wipes every register
		if (!s[`ASFM_SY_STBY_N])
			state_next = '0;
	end

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	// ==========================================
	// outputs
	assign dev_state_o = state_reg.state;
	assign charge_pump_en_o = state_reg.state != ASFM_ST_STANDBY;
	assign osc_en_o = state_reg.state != ASFM_ST_STANDBY;
	assign serial_en_o = state_reg.state != ASFM_ST_STANDBY;
	assign ramp_charge_o = (state_reg.state == ASFM_ST_RAMP_UP) || (state_reg.state == ASFM_ST_PLAY);
	assign ramp_hard_discharge_o = !running;
	assign gain_ramping_o = is_ramping(state_reg.state) && s_third && !s_two_thirds;
	assign bridge_hiz_o = chan_hiz;
	assign bridge_switch_o = {4{state_reg.phase}} & ~chan_hiz;
	assign audio_enable_o = {4{is_ramping(state_reg.state) && s_third}} & ~chan_hiz;
	assign current_limit_o = limiting;
	assign status_mute_o = state_reg.state == ASFM_ST_MUTE;
	assign status_play_o = state_reg.state == ASFM_ST_PLAY;
	assign stat_undervoltage_o = state_reg.uv;
	assign stat_charge_pump_undervoltage_o = state_reg.cpuv;
	assign stat_overvoltage_o = state_reg.ov;
	assign stat_overheat_warning_o = state_reg.overheat_warning;
	assign stat_overheat_shutdown_o = state_reg.overheat_shutdown;
	assign stat_overcurrent_o = state_reg.oc;
	assign stat_dc_fault_o = state_reg.dcf;
	assign stat_diag_open_o = state_reg.dopen;
	assign stat_diag_short_o = state_reg.dshort;
	assign diag_busy_o = state_reg.diag_busy;
	assign fault_out_o = 1'b0;
	assign fault_oe_n_o = !state_reg.fault_act;
	assign clip_heat_warning_n_o = !state_reg.clip_act;
endmodule

// file: tb/asfm_host.sv
// host controller model issuing mode and maintenance commands
`timescale 1ns/1ps
module asfm_host
(
	input wire logic clock_i,
	output logic cmd_play_o,
	output logic [3:0] cmd_hiz_o,
	output logic diag_start_o,
	output logic fault_clear_o,
	output logic [1:0] clip_select_o
);
	initial
	begin
		cmd_play_o = 1'b0;
		cmd_hiz_o = 4'h0;
		diag_start_o = 1'b0;
		fault_clear_o = 1'b0;
		clip_select_o = 2'h0;
	end
	// channels 0/1 and 2/3 are paralleled: one shared setting and command
	task automatic mode(input logic play, input logic [1:0] pair_hiz);
		@(negedge clock_i);
		cmd_play_o = play;
		cmd_hiz_o = {{2{pair_hiz[1]}}, {2{pair_hiz[0]}}};
	endtask
	task automatic pulse(input logic diag);
		@(negedge clock_i);
		diag_start_o = diag;
		fault_clear_o = !diag;
		@(negedge clock_i);
		diag_start_o = 1'b0;
		fault_clear_o = 1'b0;
	endtask
	task automatic select(input logic [1:0] s);
		@(negedge clock_i);
		clip_select_o = s;
	endtask
endmodule

// file: tb/asfm_core_chk.sv
// port assertions for the amplifier state and fault manager
`timescale 1ns/1ps
module asfm_core_chk
#(
	parameter logic [11:0] OC_TIMEOUT = 12'h9c4
)
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic standby_n_i,
	input wire logic ramp_above_nine_tenths_i,
	input wire logic por_fault_i,
	input wire logic supply_undervoltage_i,
	input wire logic fault_clear_i,
	input wire logic cmd_play_i,
	input wire asfm_pkg::asfm_state_t dev_state_o,
	input wire logic charge_pump_en_o,
	input wire logic osc_en_o,
	input wire logic serial_en_o,
	input wire logic ramp_charge_o,
	input wire logic [3:0] bridge_hiz_o,
	input wire logic [3:0] current_limit_o,
	input wire logic status_play_o,
	input wire logic stat_undervoltage_o,
	input wire logic stat_overheat_shutdown_o,
	input wire logic [3:0] stat_overcurrent_o,
	input wire logic [3:0] stat_dc_fault_o,
	input wire logic diag_busy_o,
	input wire logic fault_oe_n_o
);
	import asfm_pkg::*;
	// ==========
	// run length of limiting on channel 0
	logic [12:0] lim_reg;
	logic [12:0] lim_next;
	always_comb
		lim_next = current_limit_o[0] ? lim_reg + 13'h0001 : 13'h0000;
	always_ff @(posedge clock_i or negedge reset_n_i)
		if (!reset_n_i)
			lim_reg <= 13'h0000;
		else
			lim_reg <= lim_next;
	// ==========
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_por_held;
		por_fault_i [*3];
	endsequence
	sequence s_uv_held;
		(supply_undervoltage_i && dev_state_o != ASFM_ST_STANDBY) [*5];
	endsequence
	property p_stby;
		dev_state_o == ASFM_ST_STANDBY |-> !charge_pump_en_o && !osc_en_o && !serial_en_o && bridge_hiz_o == 4'hf;
	endproperty
	a_stby: assert property (p_stby) else $error("standby left something on");
	property p_ramp_go;
		dev_state_o == ASFM_ST_MUTE && cmd_play_i |=> ramp_charge_o;
	endproperty
	a_ramp_go: assert property (p_ramp_go) else $error("ramp did not start");
	property p_play_st;
		$rose(status_play_o) |-> $past(ramp_above_nine_tenths_i, 3);
	endproperty
	a_play_st: assert property (p_play_st) else $error("play status early");
	property p_uv;
		s_uv_held |-> stat_undervoltage_o;
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage not latched");
	property p_uv_act;
		stat_undervoltage_o [*2] |-> !fault_oe_n_o && dev_state_o inside {ASFM_ST_STANDBY, ASFM_ST_HIZ};
	endproperty
	a_uv_act: assert property (p_uv_act) else $error("undervoltage not acted on");
	property p_overheat_shutdown_hold;
		stat_overheat_shutdown_o && !fault_clear_i && standby_n_i |=> stat_overheat_shutdown_o;
	endproperty
	a_overheat_shutdown_hold: assert property (p_overheat_shutdown_hold) else $error("shutdown latch lost");
	property p_overheat_shutdown;
		stat_overheat_shutdown_o |=> dev_state_o == ASFM_ST_STANDBY;
	endproperty
	a_overheat_shutdown: assert property (p_overheat_shutdown) else $error("shutdown not standby");
	property p_por;
		s_por_held |=> dev_state_o == ASFM_ST_STANDBY && !fault_oe_n_o;
	endproperty
	a_por: assert property (p_por) else $error("power fault not acted on");
	property p_oc_time;
		lim_reg <= {1'b0, OC_TIMEOUT} + 13'h0001;
	endproperty
	a_oc_time: assert property (p_oc_time) else $error("limiting outlasted timeout");
	property p_diag;
		$rose(diag_busy_o) |-> $past(bridge_hiz_o) == 4'hf && $past(dev_state_o) != ASFM_ST_STANDBY;
	endproperty
	a_diag: assert property (p_diag) else $error("diagnostic outside hi-z");
	property p_chan;
		(stat_overcurrent_o | stat_dc_fault_o) != 4'h0 |-> ((stat_overcurrent_o | stat_dc_fault_o) & ~bridge_hiz_o) == 4'h0;
	endproperty
	a_chan: assert property (p_chan) else $error("faulty channel not hi-z");
endmodule

bind asfm_core asfm_core_chk #(.OC_TIMEOUT(OC_TIMEOUT)) i_asfm_core_chk (.*);

// file: tb/tb_asfm_core.sv
// self-checking bench for the amplifier state and fault manager
`timescale 1ns/1ps
module tb_asfm_core;
	import asfm_pkg::*;
	localparam int OC = 8;
	localparam int DG = 8;
	logic clock_i = 1'b0, reset_n_i = 1'b0, standby_n_i = 1'b1, sync_clock_i = 1'b0;
	logic ramp_above_tenth_i, ramp_above_third_i, ramp_above_two_thirds_i, ramp_above_nine_tenths_i;
	logic por_fault_i = 1'b0, supply_undervoltage_i, charge_pump_undervoltage_i, supply_overvoltage_i;
	logic load_dump_i = 1'b0, overheat_warning_i = 1'b0, overheat_shutdown_i = 1'b0;
	logic [3:0] cycle_current_limit_i = 4'h0, dc_fault_i = 4'h0, clip_detect_i = 4'h0, diag_open_i = 4'h0;
	logic cmd_play_i, diag_start_i, fault_clear_i, charge_pump_en_o, osc_en_o, serial_en_o, ramp_charge_o;
	logic [3:0] cmd_hiz_i, diag_short_i, bridge_hiz_o, bridge_switch_o, audio_enable_o, current_limit_o, sw;
	logic [1:0] clip_select_i;
	asfm_state_t dev_state_o;
	logic ramp_hard_discharge_o, gain_ramping_o, status_mute_o, status_play_o, stat_undervoltage_o;
	logic stat_charge_pump_undervoltage_o, stat_overvoltage_o, stat_overheat_warning_o, stat_overheat_shutdown_o;
	logic diag_busy_o, fault_out_o, fault_oe_n_o, clip_heat_warning_n_o;
	logic [3:0] stat_overcurrent_o, stat_dc_fault_o, stat_diag_open_o, stat_diag_short_o;
	logic [2:0] hzf = 3'h0;
	int lvl = 0, cyc = 0, error_cnt = 0, n_tests = 0;
	assign {supply_overvoltage_i, charge_pump_undervoltage_i, supply_undervoltage_i} = hzf;
	assign diag_short_i = ~diag_open_i;
	// ==========
	// ramp capacitor: slow rise and fall through the comparator levels
	assign ramp_above_tenth_i = lvl > 1;
	assign ramp_above_third_i = lvl > 3;
	assign ramp_above_two_thirds_i = lvl > 6;
	assign ramp_above_nine_tenths_i = lvl > 9;
	always @(negedge clock_i)
		lvl = (ramp_charge_o === 1'b1) ? (lvl < 10 ? lvl + 1 : 10) : (lvl > 0 ? lvl - 1 : 0);
	asfm_core #(.OC_TIMEOUT(12'h008), .DIAG_TIME(12'h008)) i_asfm_core (.*);
	asfm_host i_asfm_host (.clock_i(clock_i), .cmd_play_o(cmd_play_i), .cmd_hiz_o(cmd_hiz_i),
		.diag_start_o(diag_start_i), .fault_clear_o(fault_clear_i), .clip_select_o(clip_select_i));
	always #20 clock_i = ~clock_i;
	initial
	begin
		#13;
		forever #160 sync_clock_i = ~sync_clock_i;
	end
	// ==========
	task automatic results();
		if (error_cnt == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			error_cnt++;
			results();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_st(input asfm_state_t exp);
		for (int i = 0; i < 60 && dev_state_o !== exp; i++)
			@(negedge clock_i);
		chk(4'(dev_state_o), 4'(exp));
	endtask
	// ==========
	initial
	begin
		tick(2);
		reset_n_i = 1'b1;
		chk_st(ASFM_ST_MUTE);
		chk(charge_pump_en_o, 1'b1);
		chk(ramp_hard_discharge_o, 1'b0);
		chk(audio_enable_o, 4'h0);
		chk(bridge_hiz_o, 4'h0);
		sw = bridge_switch_o;
		tick(8);
		chk(bridge_switch_o, ~sw);
		i_asfm_host.mode(1'b1, 2'h0);
		tick(1);
		chk(ramp_charge_o, 1'b1);
		tick(6);
		chk(gain_ramping_o, 1'b1);
		chk_st(ASFM_ST_PLAY);
		chk(gain_ramping_o, 1'b0);
		chk(audio_enable_o, 4'hf);
		chk(status_play_o, 1'b1);
		i_asfm_host.mode(1'b0, 2'h0);
		tick(7);
		chk(gain_ramping_o, 1'b1);
		chk_st(ASFM_ST_MUTE);
		chk(status_mute_o, 1'b1);
		chk(audio_enable_o, 4'h0);
		for (int i = 0; i < 3; i++)
		begin
			hzf = 3'(1 << i);
			chk_st(ASFM_ST_HIZ);
			chk(fault_oe_n_o, 1'b0);
			tick(2);
			hzf = 3'h0;
			tick(4);
			chk({1'b0, stat_overvoltage_o, stat_charge_pump_undervoltage_o, stat_undervoltage_o}, 4'(1 << i));
			i_asfm_host.pulse(1'b0);
			chk_st(ASFM_ST_MUTE);
			chk(fault_oe_n_o, 1'b1);
		end
		i_asfm_host.select(2'h1);
		overheat_warning_i = 1'b1;
		tick(5);
		chk(stat_overheat_warning_o, 1'b1);
		chk(clip_heat_warning_n_o, 1'b0);
		chk(4'(dev_state_o), 4'(ASFM_ST_MUTE));
		overheat_warning_i = 1'b0;
		tick(5);
		chk(stat_overheat_warning_o, 1'b0);
		chk(clip_heat_warning_n_o, 1'b1);
		overheat_shutdown_i = 1'b1;
		chk_st(ASFM_ST_STANDBY);
		chk(fault_oe_n_o, 1'b0);
		chk(fault_out_o, 1'b0);
		chk(ramp_hard_discharge_o, 1'b1);
		overheat_shutdown_i = 1'b0;
		tick(4);
		chk(stat_overheat_shutdown_o, 1'b1);
		i_asfm_host.pulse(1'b0);
		chk_st(ASFM_ST_MUTE);
		for (int i = 0; i < 2; i++)
		begin
			{load_dump_i, por_fault_i} = 2'(1 << i);
			chk_st(ASFM_ST_STANDBY);
			chk(fault_oe_n_o, 1'b0);
			{load_dump_i, por_fault_i} = 2'h0;
			chk_st(ASFM_ST_MUTE);
			chk(fault_oe_n_o, 1'b1);
		end
		i_asfm_host.select(2'h2);
		cycle_current_limit_i = 4'h1;
		tick(OC - 1);
		chk(current_limit_o, 4'h1);
		chk(clip_heat_warning_n_o, 1'b0);
		cycle_current_limit_i = 4'h0;
		tick(1);
		cycle_current_limit_i = 4'h1;
		tick(OC - 1);
		chk(stat_overcurrent_o, 4'h0);
		tick(6);
		chk(stat_overcurrent_o, 4'h1);
		chk(bridge_hiz_o, 4'h1);
		chk(4'(dev_state_o), 4'(ASFM_ST_MUTE));
		cycle_current_limit_i = 4'h0;
		tick(3);
		i_asfm_host.pulse(1'b0);
		tick(2);
		chk(bridge_hiz_o, 4'h0);
		i_asfm_host.mode(1'b1, 2'h0);
		chk_st(ASFM_ST_PLAY);
		clip_detect_i = 4'hf;
		tick(4);
		chk(clip_heat_warning_n_o, 1'b0);
		clip_detect_i = 4'h0;
		dc_fault_i = 4'hc;
		tick(4);
		chk(stat_dc_fault_o, 4'hc);
		chk(bridge_hiz_o, 4'hc);
		chk(clip_heat_warning_n_o, 1'b1);
		chk(fault_oe_n_o, 1'b0);
		dc_fault_i = 4'h3;
		tick(4);
		chk(stat_dc_fault_o, 4'hf);
		dc_fault_i = 4'h0;
		i_asfm_host.mode(1'b0, 2'h0);
		i_asfm_host.pulse(1'b0);
		chk_st(ASFM_ST_MUTE);
		chk(stat_dc_fault_o, 4'h0);
		i_asfm_host.mode(1'b0, 2'h1);
		diag_open_i = 4'h5;
		i_asfm_host.pulse(1'b1);
		chk(diag_busy_o, 1'b0);
		i_asfm_host.mode(1'b0, 2'h3);
		i_asfm_host.pulse(1'b1);
		chk(diag_busy_o, 1'b1);
		tick(DG);
		chk(diag_busy_o, 1'b0);
		chk(stat_diag_open_o, 4'h5);
		chk(stat_diag_short_o, 4'ha);
		standby_n_i = 1'b0;
		chk_st(ASFM_ST_STANDBY);
		chk(serial_en_o, 1'b0);
		chk(osc_en_o, 1'b0);
		chk(stat_diag_open_o, 4'h0);
		standby_n_i = 1'b1;
		i_asfm_host.mode(1'b0, 2'h0);
		chk_st(ASFM_ST_MUTE);
		results();
	end
endmodule
